// ### design/flash_read_regs.svh
`ifndef FLASH_READ_REGS_SVH
`define FLASH_READ_REGS_SVH

// opcodes with the top bit dropped; bit 7 picks the clocking category
`define OPC_CONT_ARRAY 7'h68
`define OPC_PAGE_READ 7'h52
`define OPC_BUF1_READ 7'h54
`define OPC_BUF2_READ 7'h56
`define OPC_STATUS 7'h57
`define OPC_CAT_BIT 7

// last index of each counted phase (counts start at zero)
`define OPC_LAST 6'h07
`define ADDR_LAST 6'h17
`define DUMMY_ARR_LAST 6'h1F
`define DUMMY_BUF_LAST 6'h07

// field positions inside the 24-bit address word
`define ADDR_PAGE_MSB 22
`define ADDR_PAGE_LSB 10
`define ADDR_BYTE_MSB 9

// last byte of a page or buffer, and last page of the array
`define BYTE_LAST 10'h20F
`define PAGE_LAST 13'h1FFF

// status register fields
`define STAT_DENSITY 4'hD
`define STAT_RESERVED 2'h0

`endif

// ### design/flash_read_pkg.sv
package flash_read_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR = 3'h2,
    ST_DUMMY = 3'h3,
    ST_DATA = 3'h4,
    ST_IGNORE = 3'h5
  } frame_state_t;

  typedef enum logic [2:0] {
    RK_NONE = 3'h0,
    RK_ARRAY = 3'h1,
    RK_PAGE = 3'h2,
    RK_BUFFER = 3'h3,
    RK_STATUS = 3'h4
  } read_kind_t;

endpackage : flash_read_pkg

// ### design/pin_sync.sv
`timescale 1ns/1ps

module pin_sync (
  input wire logic mclk,         // system clock
  input wire logic ce,           // clock enable, freezes state when low
  input wire logic rst_sync_b,   // synchronised reset, active low
  input wire logic cs_b,         // chip select pin, active low
  input wire logic sck,          // serial clock pin
  input wire logic si,           // serial input pin
  output logic cs_low,           // chip select asserted, synchronised
  output logic si_s,             // serial input, synchronised
  output logic sck_rise,         // pulse on serial clock rising edge
  output logic sck_fall,         // pulse on serial clock falling edge
  output logic cs_fall,          // pulse when a frame opens
  output logic cs_rise           // pulse when a frame closes
);

  logic [2:0] pin_in;
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic sck_d_r;
  logic cs_d_r;

  assign pin_in = {si, sck, cs_b};

  //////////////////////////////////////////////////////////////////////////
  // two flops per pin; only the second stage is read by logic
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_sync
      always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          meta_r[i] <= (i == 1) ? 1'b0 : 1'b1;
          sync_r[i] <= (i == 1) ? 1'b0 : 1'b1;
        end else if (ce) begin
          meta_r[i] <= pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else if (ce) begin
      sck_d_r <= sync_r[1];
      cs_d_r <= sync_r[0];
    end
  end

  assign cs_low = !sync_r[0];
  assign si_s = sync_r[2];
  assign sck_rise = ce && sync_r[1] && !sck_d_r;
  assign sck_fall = ce && !sync_r[1] && sck_d_r;
  assign cs_fall = ce && !sync_r[0] && cs_d_r;
  assign cs_rise = ce && sync_r[0] && !cs_d_r;

endmodule : pin_sync

// ### design/serial_flash_read_command_unit.sv
`timescale 1ns/1ps
`include "flash_read_regs.svh"

module serial_flash_read_command_unit
  import flash_read_pkg::*;
(
  input wire logic mclk,                // system clock, 20 MHz
  input wire logic rst_b,               // asynchronous reset, active low
  input wire logic ce,                  // clock enable
  input wire logic cs_b,                // chip select pin, active low
  input wire logic sck,                 // serial clock pin
  input wire logic si,                  // serial input pin
  output logic so,                      // serial output data
  output logic so_oe,                   // serial output driven when high
  input wire logic busy,                // internal operation in progress
  input wire logic comp_mismatch,       // last compare found a difference
  output logic [12:0] page_addr,        // array page being read
  output logic [9:0] page_byte_addr,    // array byte being read
  input wire logic [7:0] arr_data,      // array byte at page/byte address
  output logic buf_sel,                 // buffer two selected when high
  output logic [9:0] buffer_byte_addr,  // buffer byte being read
  input wire logic [7:0] buf_data       // buffer byte at buffer address
);

  logic rst_meta_r;
  logic rst_sync_b;
  logic cs_low;
  logic si_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  frame_state_t state_r;
  frame_state_t state_nxt;
  read_kind_t kind_r;
  read_kind_t opc_kind;
  logic legacy_r;
  logic [5:0] bit_cnt_r;
  logic [5:0] dummy_last;
  logic phase_end;
  logic [6:0] op_sh_r;
  logic [7:0] opc_full;
  logic [22:0] addr_sh_r;
  logic [23:0] addr_full;
  logic [12:0] page_addr_r;
  logic [9:0] page_byte_addr_r;
  logic [9:0] buffer_byte_addr_r;
  logic buf_sel_r;
  logic [7:0] status_byte;
  logic [7:0] src_byte;
  logic [7:0] byte_r;
  logic [2:0] bit_idx_r;
  logic so_r;
  logic shift_ev;
  logic fetch;

  //////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion is still immediate
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  pin_sync u_pin_sync (
    .mclk(mclk),
    .ce(ce),
    .rst_sync_b(rst_sync_b),
    .cs_b(cs_b),
    .sck(sck),
    .si(si),
    .cs_low(cs_low),
    .si_s(si_s),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .cs_fall(cs_fall),
    .cs_rise(cs_rise)
  );

  //////////////////////////////////////////////////////////////////////////
  // opcode decode; the top bit only selects the clocking category
  assign opc_full = {op_sh_r, si_s};

  always_comb begin
    case (opc_full[6:0])
      `OPC_CONT_ARRAY: opc_kind = RK_ARRAY;
      `OPC_PAGE_READ: opc_kind = RK_PAGE;
      `OPC_BUF1_READ, `OPC_BUF2_READ: opc_kind = RK_BUFFER;
      `OPC_STATUS: opc_kind = RK_STATUS;
      default: opc_kind = RK_NONE;
    endcase
  end

  assign dummy_last = (kind_r == RK_BUFFER) ? `DUMMY_BUF_LAST
                                            : `DUMMY_ARR_LAST;

  always_comb begin
    case (state_r)
      ST_OPCODE: phase_end = (bit_cnt_r == `OPC_LAST);
      ST_ADDR: phase_end = (bit_cnt_r == `ADDR_LAST);
      ST_DUMMY: phase_end = (bit_cnt_r == dummy_last);
      default: phase_end = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_comb begin
    state_nxt = state_r;
    if (cs_rise) begin
      state_nxt = ST_IDLE;
    end else if (cs_fall) begin
      state_nxt = ST_OPCODE;
    end else if (sck_rise && phase_end) begin
      case (state_r)
        ST_OPCODE: begin
          if (opc_kind == RK_NONE) begin
            state_nxt = ST_IGNORE;
          end else if (opc_kind == RK_STATUS) begin
            state_nxt = ST_DATA;
          end else begin
            state_nxt = ST_ADDR;
          end
        end
        ST_ADDR: state_nxt = ST_DUMMY;
        ST_DUMMY: state_nxt = ST_DATA;
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // bit counter restarts at every phase change
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bit_cnt_r <= 6'h00;
    end else if (ce) begin
      if (cs_fall || (sck_rise && phase_end)) begin
        bit_cnt_r <= 6'h00;
      end else if (sck_rise && state_r inside {ST_OPCODE, ST_ADDR,
                                               ST_DUMMY}) begin
        bit_cnt_r <= 6'(bit_cnt_r + 6'h01);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // opcode and address shifters, msb first
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      op_sh_r <= 7'h00;
      addr_sh_r <= 23'h000000;
    end else if (ce && sck_rise) begin
      if (state_r == ST_OPCODE) begin
        op_sh_r <= opc_full[6:0];
      end
      if (state_r == ST_ADDR) begin
        addr_sh_r <= addr_full[22:0];
      end
    end
  end

  assign addr_full = {addr_sh_r, si_s};

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      kind_r <= RK_NONE;
      legacy_r <= 1'b0;
      buf_sel_r <= 1'b0;
    end else if (ce && sck_rise && phase_end && state_r == ST_OPCODE) begin
      kind_r <= opc_kind;
      legacy_r <= !opc_full[`OPC_CAT_BIT];
      buf_sel_r <= (opc_full[6:0] == `OPC_BUF2_READ);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address counters; the reserved top address bit is dropped
  assign fetch = shift_ev && (bit_idx_r == 3'h0);

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      page_addr_r <= 13'h0000;
      page_byte_addr_r <= 10'h000;
    end else if (ce) begin
      if (sck_rise && phase_end && state_r == ST_ADDR) begin
        page_addr_r <= addr_full[`ADDR_PAGE_MSB:`ADDR_PAGE_LSB];
        page_byte_addr_r <= addr_full[`ADDR_BYTE_MSB:0];
      end else if (fetch && kind_r inside {RK_ARRAY, RK_PAGE}) begin
        if (page_byte_addr_r == `BYTE_LAST) begin
          page_byte_addr_r <= 10'h000;
          if (kind_r == RK_ARRAY) begin
            page_addr_r <= 13'(page_addr_r + 13'h0001);
          end
        end else begin
          page_byte_addr_r <= 10'(page_byte_addr_r + 10'h001);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      buffer_byte_addr_r <= 10'h000;
    end else if (ce) begin
      if (sck_rise && phase_end && state_r == ST_ADDR) begin
        buffer_byte_addr_r <= addr_full[`ADDR_BYTE_MSB:0];
      end else if (fetch && kind_r == RK_BUFFER) begin
        if (buffer_byte_addr_r == `BYTE_LAST) begin
          buffer_byte_addr_r <= 10'h000;
        end else begin
          buffer_byte_addr_r <= 10'(buffer_byte_addr_r + 10'h001);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output shifter; status is sampled anew at the start of each pass
  assign status_byte = {!busy, comp_mismatch, `STAT_DENSITY,
                        `STAT_RESERVED};

  always_comb begin
    case (kind_r)
      RK_STATUS: src_byte = status_byte;
      RK_BUFFER: src_byte = buf_data;
      default: src_byte = arr_data;
    endcase
  end

  // legacy category shifts on rising edges, spi category on falling
  assign shift_ev = (state_r == ST_DATA) &&
                    (legacy_r ? sck_rise : sck_fall) && !cs_rise;

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      byte_r <= 8'h00;
      bit_idx_r <= 3'h0;
      so_r <= 1'b0;
    end else if (ce) begin
      if (state_r != ST_DATA) begin
        bit_idx_r <= 3'h0;
        so_r <= 1'b0;
      end else if (shift_ev) begin
        if (bit_idx_r == 3'h0) begin
          byte_r <= src_byte;
          so_r <= src_byte[7];
        end else begin
          so_r <= byte_r[3'(3'h7 - bit_idx_r)];
        end
        bit_idx_r <= 3'(bit_idx_r + 3'h1);
      end
    end
  end

  assign so = so_r;
  assign so_oe = (state_r == ST_DATA);
  assign page_addr = page_addr_r;
  assign page_byte_addr = page_byte_addr_r;
  assign buffer_byte_addr = buffer_byte_addr_r;
  assign buf_sel = buf_sel_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  a_opcode_length: assert property (
    (state_r == ST_OPCODE && sck_rise && bit_cnt_r == `OPC_LAST && !cs_rise)
    |=> state_r != ST_OPCODE
  ) else $error("opcode phase did not end after eight bits");

  a_msb_order: assert property (
    (shift_ev && ce && bit_idx_r != 3'h0)
    |=> so == $past(byte_r[3'(3'h7 - bit_idx_r)])
  ) else $error("data bit out of order");

  a_array_dummy: assert property (
    (state_r == ST_DUMMY && kind_r != RK_BUFFER && sck_rise && ce &&
     bit_cnt_r != `DUMMY_ARR_LAST && !cs_rise && !cs_fall)
    |=> state_r == ST_DUMMY
  ) else $error("array read left dummy phase early");

  a_page_cross: assert property (
    (fetch && ce && kind_r == RK_ARRAY && page_byte_addr_r == `BYTE_LAST &&
     page_addr_r != `PAGE_LAST)
    |=> page_byte_addr_r == 10'h000 &&
        page_addr_r == 13'($past(page_addr_r) + 13'h0001)
  ) else $error("page crossover wrong");

  a_array_wrap: assert property (
    (fetch && ce && kind_r == RK_ARRAY && page_byte_addr_r == `BYTE_LAST &&
     page_addr_r == `PAGE_LAST)
    |=> page_addr_r == 13'h0000 && page_byte_addr_r == 10'h000
  ) else $error("array end did not wrap to start");

  a_cs_release: assert property (
    (cs_rise && ce) |=> !so_oe [*2]
  ) else $error("output still driven after select high");

  a_page_wrap: assert property (
    (fetch && ce && kind_r == RK_PAGE && page_byte_addr_r == `BYTE_LAST)
    |=> page_byte_addr_r == 10'h000 && $stable(page_addr_r)
  ) else $error("page read did not wrap in page");

  a_buffer_wrap: assert property (
    (fetch && ce && kind_r == RK_BUFFER && buffer_byte_addr_r == `BYTE_LAST)
    |=> buffer_byte_addr_r == 10'h000
  ) else $error("buffer read did not wrap");

  a_status_ready: assert property (
    (fetch && ce && kind_r == RK_STATUS) |=> so == !$past(busy)
  ) else $error("ready bit wrong");

  a_category_bit: assert property (
    (sck_rise && phase_end && state_r == ST_OPCODE)
    |=> legacy_r == !$past(op_sh_r[6])
  ) else $error("clocking category not taken from opcode top bit");

  a_ignore_quiet: assert property (
    (state_r == ST_IGNORE && !cs_rise) |=> state_r == ST_IGNORE && !so_oe
  ) else $error("output driven for unknown opcode");

  c_array_data: cover property (state_r == ST_DATA && kind_r == RK_ARRAY);
  c_status_pass: cover property (fetch && kind_r == RK_STATUS &&
                                 bit_idx_r == 3'h0 && legacy_r);
  c_buffer_wrap: cover property (fetch && kind_r == RK_BUFFER &&
                                 buffer_byte_addr_r == `BYTE_LAST);
  c_ignore: cover property (state_r == ST_IGNORE && cs_rise);

endmodule : serial_flash_read_command_unit

// ### verif/host_model.sv
`timescale 1ns/1ps

module host_model (
  input wire logic mclk,   // system clock
  output logic cs_b,       // chip select, active low
  output logic sck,        // serial clock, idles low
  output logic si,         // serial data to the device
  input wire logic so,     // serial data from the device
  input wire logic so_oe   // device drives so when high
);
  logic [7:0] rx [0:7];
  logic oe_l;
  logic oe_s;
  int n_oe_miss;
  int n_oe_hi;

  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_clk

  ////////////////////////////////////////////////////////////////////////////
  // one sck period is 8 mclk; so is sampled 1.5 mclk after each phase
  // change plus the device lag, clear of the 3-4 mclk shifting delay
  task automatic bit_cycle(input logic d, output logic s_leg,
                           output logic s_spi);
    @(posedge mclk);
    sck <= 1'b0;
    si <= d;
    @(posedge mclk);
    @(negedge mclk);
    // a released line reads inverted so a missing enable corrupts data
    s_leg = so_oe ? so : !so;
    oe_l = so_oe;
    repeat (3) @(posedge mclk);
    sck <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    s_spi = so_oe ? so : !so;
    oe_s = so_oe;
    repeat (2) @(posedge mclk);
  endtask : bit_cycle

  ////////////////////////////////////////////////////////////////////////////
  // legacy opcodes shift on rising sck, so their bits are read one
  // period later than the spi ones
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                       input int n_adr, input int n_dum, input int n_bytes);
    int first;
    int last;
    int j;
    logic d;
    logic sl;
    logic ss;
    first = 8 + n_adr + n_dum;
    last = first + 8 * n_bytes;
    n_oe_miss = 0;
    n_oe_hi = 0;
    @(posedge mclk);
    cs_b <= 1'b0;
    wait_clk(4);
    for (int k = 0; k <= last; k++) begin
      if (k < 8)
        d = opc[7 - k];
      else if (k < 8 + n_adr)
        d = adr[31 - k];
      else
        d = k[0];
      bit_cycle(d, sl, ss);
      j = opc[7] ? k - first : k - first - 1;
      if (oe_l !== 1'b0 || oe_s !== 1'b0)
        n_oe_hi++;
      if (j >= 0 && j < 8 * n_bytes) begin
        rx[j / 8][7 - j % 8] = opc[7] ? ss : sl;
        if ((opc[7] ? oe_s : oe_l) !== 1'b1)
          n_oe_miss++;
      end
    end
    @(posedge mclk);
    sck <= 1'b0;
    repeat (4) @(posedge mclk);
    cs_b <= 1'b1;
    wait_clk(8);
  endtask : frame
endmodule : host_model

// ### verif/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic busy = 1'b0;
  logic comp_mismatch = 1'b1;
  logic cs_b;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic [12:0] page_addr;
  logic [9:0] page_byte_addr;
  logic [7:0] arr_data;
  logic buf_sel;
  logic [9:0] buffer_byte_addr;
  logic [7:0] buf_data;
  logic [7:0] opc_t [0:7];
  logic [23:0] adr_t [0:7];
  int n_fail = 0;
  int num_checks = 0;

  always #25 mclk = ~mclk;

  // memory contents are a pattern that differs with the low four page bits and per buffer
  function automatic logic [7:0] arr_fn(logic [12:0] p, logic [9:0] b);
    return b[7:0] ^ {p[3:0], 2'h0, b[9:8]};
  endfunction : arr_fn

  function automatic logic [7:0] buf_fn(logic s, logic [9:0] a);
    return a[7:0] ^ {s, 5'h00, a[9:8]};
  endfunction : buf_fn

  assign arr_data = arr_fn(page_addr, page_byte_addr);
  assign buf_data = buf_fn(buf_sel, buffer_byte_addr);

  host_model host (.mclk(mclk), .cs_b(cs_b), .sck(sck), .si(si), .so(so),
                   .so_oe(so_oe));

  serial_flash_read_command_unit dut (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .cs_b(cs_b), .sck(sck), .si(si),
    .so(so), .so_oe(so_oe), .busy(busy), .comp_mismatch(comp_mismatch),
    .page_addr(page_addr), .page_byte_addr(page_byte_addr),
    .arr_data(arr_data), .buf_sel(buf_sel),
    .buffer_byte_addr(buffer_byte_addr), .buf_data(buf_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic check_frame_end();
    check("oe during data", 8'(host.n_oe_miss), 8'h00);
    check("oe after close", {7'h00, so_oe}, 8'h00);
  endtask : check_frame_end

  // status bits 1:0 are undefined and left out of the compare
  task automatic check_status(input int n, input logic bsy, input logic cm);
    check("status", {2'h0, host.rx[n][7:2]}, {2'h0, ~bsy, cm, 4'hD});
  endtask : check_status

  ////////////////////////////////////////////////////////////////////////////
  // three bytes across every wrap point, each read command in both clocking categories
  task automatic read_table(input int i);
    logic [12:0] p;
    logic [9:0] b;
    p = adr_t[i][22:10];
    b = adr_t[i][9:0];
    host.frame(opc_t[i], adr_t[i], 24, (i < 4) ? 32 : 8, 3);
    for (int n = 0; n < 3; n++) begin
      check("read byte", host.rx[n],
            (i >= 4) ? buf_fn(opc_t[i][1], b) : arr_fn(p, b));
      if (b == 10'h20F) begin
        b = 10'h000;
        if (i < 2)
          p = p + 13'h0001;
      end else begin
        b = b + 10'h001;
      end
    end
    check_frame_end();
  endtask : read_table

  initial begin
    opc_t = '{8'h68, 8'hE8, 8'h52, 8'hD2, 8'h54, 8'hD4, 8'h56, 8'hD6};
    adr_t = '{{1'b0, 13'h0005, 10'h20F}, {1'b1, 13'h1FFF, 10'h20E},
              {1'b1, 13'h0003, 10'h20E}, {1'b0, 13'h0003, 10'h20F},
              {14'h2AAA, 10'h20E}, {14'h1555, 10'h20F},
              {14'h2AAA, 10'h20E}, {14'h1555, 10'h20F}};
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    // status: busy rises mid first byte, the next pass must show it
    fork
      host.frame(8'hD7, 24'h000000, 0, 0, 3);
      begin
        repeat (100) @(posedge mclk);
        busy <= 1'b1;
      end
    join
    check_status(0, 1'b0, 1'b1);
    check_status(1, 1'b1, 1'b1);
    check_status(2, 1'b1, 1'b1);
    check_frame_end();
    @(posedge mclk);
    busy <= 1'b0;
    comp_mismatch <= 1'b0;
    host.frame(8'hA5, 24'h123456, 24, 8, 1);
    check("oe on unknown", 8'(host.n_oe_hi), 8'h00);
    host.frame(8'h57, 24'h000000, 0, 0, 1);
    check_status(0, 1'b0, 1'b0);
    check_frame_end();
    for (int i = 0; i < 8; i++)
      read_table(i);
    finish_test();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
endmodule : testbench
